//--- testbench/eqt_mac_model.sv
`timescale 1ns/1ps
module eqt_mac_model
    import eqt_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          stall,
    output logic      [NP-1:0] eg_ready
);
    // registered, like a real mac: back-pressure lands one edge late
    always_ff @(posedge ref_clk) begin
        eg_ready <= (!reset_n || stall) ? '0 : '1;
    end
endmodule

//--- testbench/eqt_tagger_props.sv
`timescale 1ns/1ps
module eqt_tagger_props
    import eqt_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              reset_n,
    input wire logic [7:0]        reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              in_valid,
    input wire logic [0:0]        in_dport,
    input wire logic [NP-1:0]     eg_ready,
    input wire logic [NP-1:0]     eg_valid,
    input wire logic [NP*14-1:0]  eg_len,
    input wire logic [15:0]       eg_etype
);
    wire in0 = in_valid && !in_dport[0];
    wire in1 = in_valid && in_dport[0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h20 |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_etype_legal: assert property (eg_etype == ETYPE_STD || eg_etype == ETYPE_ALT)
        else $error("provider ethertype illegal");
    a_etype_quiet: assert property (
        !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(eg_etype))
        else $error("ethertype moved without a write");
    a_hold_port0: assert property (
        eg_valid[0] && !eg_ready[0] |=> eg_valid[0] && $stable(eg_len[13:0]))
        else $error("port 0 descriptor not held");
    a_hold_port1: assert property (
        eg_valid[1] && !eg_ready[1] |=> eg_valid[1] && $stable(eg_len[27:14]))
        else $error("port 1 descriptor not held");
    // a rise means the queues were empty, so only a frame two edges back can cause it
    a_first_port0: assert property ($rose(eg_valid[0]) |-> $past(in0, 2))
        else $error("port 0 output without cause");
    a_first_port1: assert property ($rose(eg_valid[1]) |-> $past(in1, 2))
        else $error("port 1 output without cause");
endmodule
bind eqt_tagger eqt_tagger_props eqt_tagger_props_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_dport(in_dport), .eg_ready(eg_ready), .eg_valid(eg_valid),
    .eg_len(eg_len), .eg_etype(eg_etype));

//--- testbench/eqt_tagger_tb.sv
`timescale 1ns/1ps
module eqt_tagger_tb;
    import eqt_pkg::*;
    logic             ref_clk = 0, reset_n = 0, stall = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
    logic             in_valid = 0;
    logic [0:0]       in_port = 0, in_dport = 0;
    logic [7:0]       reg_addr = 0;
    logic [31:0]      reg_wdata = 0, reg_rdata;
    logic [NP-1:0]    eg_ready, eg_valid, eg_ctag, eg_stag;
    logic [NP*3-1:0]  eg_pcp, eg_spcp;
    logic [NP*12-1:0] eg_vid, eg_svid;
    logic [NP*14-1:0] eg_len;
    logic [15:0]      eg_etype;
    eqt_entry_t       fr = '0, ob, fs [11], eq [NP][$];
    logic [31:0]      rq [$];
    int               seed = 32'h5a01, num_errors = 0, comparisons = 0;
    int               cnt [4] = '{default: 0}, cl [8] = '{1, 0, 0, 1, 2, 2, 3, 3};
    eqt_tagger eqt_tagger_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_port(in_port), .in_dport(in_dport), .in_tagged(fr.ctag),
        .in_pcp(fr.pcp), .in_vid(fr.vid), .in_len(fr.len), .in_stag(fr.stag),
        .in_spcp(fr.spcp), .in_svid(fr.svid), .eg_ready(eg_ready), .eg_valid(eg_valid),
        .eg_ctag(eg_ctag), .eg_pcp(eg_pcp), .eg_vid(eg_vid), .eg_len(eg_len),
        .eg_stag(eg_stag), .eg_spcp(eg_spcp), .eg_svid(eg_svid), .eg_etype(eg_etype));
    eqt_mac_model eqt_mac_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .stall(stall),
        .eg_ready(eg_ready));
    initial forever #20 ref_clk = ~ref_clk;
    task automatic check(input string n, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // absent tags leave their fields undefined, so both sides hide them
    function automatic eqt_entry_t vw(input eqt_entry_t e);
        vw = e;
        if (!e.ctag) {vw.pcp, vw.vid} = '0;
        if (!e.stag) {vw.spcp, vw.svid} = '0;
    endfunction
    function automatic eqt_entry_t mk(logic t, logic [2:0] p, logic [13:0] l, logic s,
                                      logic [2:0] sp, logic [11:0] sv);
        mk = '{t, p, 12'h0A5, l, s, sp, sv};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
    endtask
    task automatic send(input logic [0:0] sp, dp, input eqt_entry_t e);
        @(posedge ref_clk);
        in_valid <= 1;
        in_port <= sp;
        in_dport <= dp;
        fr <= e;
        @(posedge ref_clk);
        in_valid <= 0;
    endtask
    always @(posedge ref_clk) begin
        if (rd_d) check("reg_rdata", reg_rdata, rq.pop_front());
        rd_d <= reg_rd;
        for (int p = 0; p < NP; p++) begin
            if (eg_valid[p] === 1'b1 && eg_ready[p]) begin
                ob = '{eg_ctag[p], eg_pcp[p*3+:3], eg_vid[p*12+:12], eg_len[p*14+:14],
                       eg_stag[p], eg_spcp[p*3+:3], eg_svid[p*12+:12]};
                check("egress", vw(ob), vw(eq[p].pop_front()));
            end
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1;
        check("eg_etype", eg_etype, ETYPE_STD);
        rd(REG_MAP, 32'h0000_FA41);
        rd(REG_PCFG0, 32'h0000_0001);
        rd(8'h20, 32'h0000_0000);
        // mac stalled: one frame per level, then top-class frames past the depth
        for (int k = 0; k < 11; k++) begin
            fs[k] = mk(1, (k < 8) ? 3'(k) : 3'h7, 14'(64 + ($random(seed) & 255)), 0, 0, 0);
            send(0, 0, fs[k]);
        end
        eq[0].push_back(fs[0]);
        for (int c = 3; c >= 0; c--) begin
            for (int k = 1; k < 11; k++) begin
                if (cl[fs[k].pcp] == c && cnt[c]++ < DEPTH) eq[0].push_back(fs[k]);
            end
        end
        rd(REG_STATUS, 32'h0000_000F);
        rd(REG_DROPS, 32'h0000_0001);
        stall <= 0;
        // let the backlog drain so later frames cannot overtake it by class
        repeat (20) @(posedge ref_clk);
        wr(REG_PCFG1, 32'h0001_6123);
        eq[0].push_back(mk(1, 3'h3, 14'h0044, 1, 3'h3, 12'h123));
        send(1, 0, mk(1, 3'h3, 14'h0040, 0, 0, 0));
        eq[0].push_back(mk(0, 3'h0, 14'h0044, 1, 3'h6, 12'h123));
        send(1, 0, mk(0, 3'h0, 14'h0040, 0, 0, 0));
        wr(REG_PCFG1, 32'h0001_E123);
        eq[0].push_back(mk(1, 3'h3, 14'h0044, 1, 3'h6, 12'h123));
        send(1, 0, mk(1, 3'h3, 14'h0040, 0, 0, 0));
        wr(REG_PCFG1, 32'h0006_0000);
        eq[1].push_back(mk(0, 3'h0, 14'h0040, 0, 3'h0, 12'h000));
        send(0, 1, mk(1, 3'h2, 14'h0048, 1, 3'h5, 12'h077));
        wr(REG_ETYPE, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        check("eg_etype", eg_etype, ETYPE_ALT);
        rd(REG_ETYPE, 32'h0000_0001);
        wr(REG_MAP, 32'h0000_1B1B);
        rd(REG_MAP, 32'h0000_1B1B);
        for (int i = 0; i < 200 && eq[0].size() + eq[1].size() + rq.size() > 0; i++)
            @(posedge ref_clk);
        check("pending", eq[0].size() + eq[1].size(), 0);
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        report_and_stop();
    end
endmodule

//--- verilog/eqt_pkg.sv
package eqt_pkg;

    localparam int NP    = 2;
    localparam int NQ    = 4;
    localparam int NQT   = NP * NQ;
    localparam int DEPTH = 4;

    localparam logic [7:0] REG_MAP    = 8'h00;
    localparam logic [7:0] REG_ETYPE  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DROPS  = 8'h0C;
    localparam logic [7:0] REG_PCFG0  = 8'h10;
    localparam logic [7:0] REG_PCFG1  = 8'h14;

    localparam logic [15:0] MAP_RST   = 16'hFA41;
    localparam logic [15:0] ETYPE_STD = 16'h8100;
    localparam logic [15:0] ETYPE_ALT = 16'hFFFF;
    localparam logic [18:0] PCFG_RST  = 19'h0_0001;
    localparam logic [13:0] TAG_BYTES = 14'h0004;
    localparam logic [15:0] DROPS_MAX = 16'hFFFF;

    localparam int PCFG_VID_LSB = 0;
    localparam int PCFG_PCP_LSB = 12;
    localparam int PCFG_FIX     = 15;
    localparam int PCFG_PUSH    = 16;
    localparam int PCFG_POP     = 17;
    localparam int PCFG_STRIP   = 18;

    typedef struct packed {
        logic        ctag;
        logic [2:0]  pcp;
        logic [11:0] vid;
        logic [13:0] len;
        logic        stag;
        logic [2:0]  spcp;
        logic [11:0] svid;
    } eqt_entry_t;

    function automatic logic [1:0] cos_of(input logic [15:0] map, input logic [2:0] prio);
        cos_of = map[{prio, 1'b0} +: 2];
    endfunction

    function automatic logic [1:0] hi_class(input logic [3:0] busy);
        if (busy[3]) begin
            hi_class = 2'h3;
        end else if (busy[2]) begin
            hi_class = 2'h2;
        end else if (busy[1]) begin
            hi_class = 2'h1;
        end else begin
            hi_class = 2'h0;
        end
    endfunction

endpackage

//--- verilog/eqt_tagger.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - eight priority levels 0..7 feed class selection
// RQ2 - explicit priority is the tag's 3-bit field
// RQ3 - priority and vlan id never influence each other
// RQ4 - four class queues per output port
// RQ5 - class 0 lowest, class 3 highest
// RQ6 - writable priority-to-class table, standard default mapping
// RQ7 - strict priority: lower queue waits for higher ones
// RQ8 - each queue is first in, first out
// RQ9 - tagged uses tag priority, untagged uses port priority
// RQ10 - egress rewrites tag priority or strips tag per port; the code only strips, tag priority passes through unchanged
// RQ11 - same classes and scheduling on every port
// RQ12 - provider tag pushed at provider ingress edge
// RQ13 - provider tag popped at provider egress edge
// RQ14 - push adds four bytes, pop removes four
// RQ15 - provider ethertype selectable: 8100 or ffff
// RQ16 - provider priority fixed per port or copied
// RQ17 - full queue drops new frame, queued frames kept
module eqt_tagger
    import eqt_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    input  wire logic                in_valid,
    input  wire logic [0:0]          in_port,
    input  wire logic [0:0]          in_dport,
    input  wire logic                in_tagged,
    input  wire logic [2:0]          in_pcp,
    input  wire logic [11:0]         in_vid,
    input  wire logic [13:0]         in_len,
    input  wire logic                in_stag,
    input  wire logic [2:0]          in_spcp,
    input  wire logic [11:0]         in_svid,
    input  wire logic [NP-1:0]       eg_ready,
    output logic      [NP-1:0]       eg_valid,
    output logic      [NP-1:0]       eg_ctag,
    output logic      [NP*3-1:0]     eg_pcp,
    output logic      [NP*12-1:0]    eg_vid,
    output logic      [NP*14-1:0]    eg_len,
    output logic      [NP-1:0]       eg_stag,
    output logic      [NP*3-1:0]     eg_spcp,
    output logic      [NP*12-1:0]    eg_svid,
    output logic      [15:0]         eg_etype
);

    logic [15:0]      map_reg;
    logic [15:0]      etype_reg;
    logic [18:0]      pcfg_reg [NP];
    logic [15:0]      drops_reg;
    logic [31:0]      rdata_reg;
    eqt_entry_t       mem_reg [NQT*DEPTH];
    logic [1:0]       wptr_reg [NQT];
    logic [1:0]       rptr_reg [NQT];
    logic [2:0]       cnt_reg [NQT];
    logic             egv_reg [NP];
    eqt_entry_t       ego_reg [NP];

    // ingress classification, all combinational on the request cycle
    wire logic [18:0] cfg_in   = pcfg_reg[in_port];
    wire logic [2:0]  port_pri = cfg_in[PCFG_PCP_LSB +: 3];
    wire logic        fix_pri  = cfg_in[PCFG_FIX];
    wire logic        push_en  = cfg_in[PCFG_PUSH];
    wire logic [11:0] port_vid = cfg_in[PCFG_VID_LSB +: 12];

    // an untagged frame takes its priority from the ingress port
    wire logic [2:0]  prio_c   = in_tagged ? in_pcp : port_pri; // RQ9 RQ2
    // a frame already provider-tagged is never pushed a second time
    wire logic        push     = push_en & ~in_stag; // RQ12
    wire logic [2:0]  spcp_new = fix_pri ? port_pri : prio_c; // RQ16
    wire logic [13:0] len_in   = push ? in_len + TAG_BYTES : in_len; // RQ14
    wire logic        stag_in  = in_stag | push;
    wire logic [2:0]  spcp_in  = push ? spcp_new : in_spcp;
    wire logic [11:0] svid_in  = push ? port_vid : in_svid;

    // the outer tag governs queueing; vid is never consulted here
    wire logic [2:0]  qprio    = stag_in ? spcp_in : prio_c; // RQ3 RQ1
    wire logic [1:0]  cls      = cos_of(map_reg, qprio); // RQ6 RQ4
    wire logic [2:0]  wq       = {in_dport, cls};
    wire logic        q_full   = (cnt_reg[wq] == 3'(DEPTH));
    wire logic        enq      = in_valid & ~q_full; // RQ17
    wire logic        drop     = in_valid & q_full; // RQ17
    wire logic [4:0]  widx     = {wq, wptr_reg[wq]};

    // descriptor as it is stored in the queue
    eqt_entry_t ent_in;
    assign ent_in.ctag = in_tagged;
    assign ent_in.pcp  = prio_c;
    assign ent_in.vid  = in_vid;
    assign ent_in.len  = len_in;
    assign ent_in.stag = stag_in;
    assign ent_in.spcp = spcp_in;
    assign ent_in.svid = svid_in;

    logic [NQT-1:0]  deq;
    eqt_entry_t      eg_next [NP];
    logic [NP-1:0]   deq_go;

    genvar p, c;
    generate
        for (p = 0; p < NP; p++) begin : g_port // RQ11
            logic [3:0]  busy;
            logic [1:0]  sel;
            logic [2:0]  rq;
            eqt_entry_t  head;
            logic        pop_t;
            logic        strip_t;
            for (c = 0; c < NQ; c++) begin : g_cls
                assign busy[c] = (cnt_reg[p*NQ+c] != 3'h0);
                assign deq[p*NQ+c] = deq_go[p] & (sel == 2'(c));
            end
            // strict priority, highest class first
            assign sel     = hi_class(busy); // RQ7 RQ5
            assign rq      = 3'(p*NQ) + {1'b0, sel};
            assign head    = mem_reg[{rq, rptr_reg[rq]}]; // RQ8
            assign deq_go[p] = (|busy) & (~egv_reg[p] | eg_ready[p]);

            wire logic        pop_en    = pcfg_reg[p][PCFG_POP];
            wire logic        strip_en  = pcfg_reg[p][PCFG_STRIP];
            assign pop_t   = pop_en & head.stag; // RQ13
            assign strip_t = strip_en & head.ctag; // RQ10

            // each removed tag takes its four bytes with it
            wire logic [13:0] cut_pop   = pop_t ? TAG_BYTES : 14'h0000; // RQ14
            wire logic [13:0] cut_strip = strip_t ? TAG_BYTES : 14'h0000;

            always_comb begin
                eg_next[p]      = head;
                eg_next[p].stag = head.stag & ~pop_t;
                eg_next[p].ctag = head.ctag & ~strip_t;
                eg_next[p].len  = head.len - cut_pop - cut_strip;
            end

            assign eg_valid[p]         = egv_reg[p];
            assign eg_ctag[p]          = ego_reg[p].ctag;
            assign eg_pcp[p*3 +: 3]    = ego_reg[p].pcp; // RQ10
            assign eg_vid[p*12 +: 12]  = ego_reg[p].vid;
            assign eg_len[p*14 +: 14]  = ego_reg[p].len;
            assign eg_stag[p]          = ego_reg[p].stag;
            assign eg_spcp[p*3 +: 3]   = ego_reg[p].spcp;
            assign eg_svid[p*12 +: 12] = ego_reg[p].svid;

            // valid falls only once the mac has taken the word and nothing waits
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    egv_reg[p] <= 1'b0;
                end else if (deq_go[p]) begin
                    egv_reg[p] <= 1'b1;
                end else if (eg_ready[p]) begin
                    egv_reg[p] <= 1'b0;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    ego_reg[p] <= '0;
                end else if (deq_go[p]) begin
                    ego_reg[p] <= eg_next[p];
                end
            end
        end
    endgenerate

    // queue pointers; a full queue refuses even when it drains this cycle
    logic [NQT-1:0] enq_q;
    genvar q;
    generate
        for (q = 0; q < NQT; q++) begin : g_queue
            assign enq_q[q] = enq & (wq == 3'(q));

            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    wptr_reg[q] <= 2'h0;
                end else if (enq_q[q]) begin
                    wptr_reg[q] <= wptr_reg[q] + 2'h1; // RQ8
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    rptr_reg[q] <= 2'h0;
                end else if (deq[q]) begin
                    rptr_reg[q] <= rptr_reg[q] + 2'h1;
                end
            end

            // a write and a read in one cycle leave the count alone
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    cnt_reg[q] <= 3'h0;
                end else if (enq_q[q] && !deq[q]) begin
                    cnt_reg[q] <= cnt_reg[q] + 3'h1;
                end else if (deq[q] && !enq_q[q]) begin
                    cnt_reg[q] <= cnt_reg[q] - 3'h1; // RQ17
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (enq) begin
            mem_reg[widx] <= ent_in;
        end
    end

    // register file
    wire logic        hit_map   = (reg_addr == REG_MAP);
    wire logic        hit_etype = (reg_addr == REG_ETYPE);
    wire logic        hit_stat  = (reg_addr == REG_STATUS);
    wire logic        hit_drops = (reg_addr == REG_DROPS);
    wire logic        pcfg_hit  = (reg_addr == REG_PCFG0) | (reg_addr == REG_PCFG1);
    wire logic [0:0]  pcfg_idx  = reg_addr[2];

    wire logic        wr_map    = reg_wr & hit_map;
    wire logic        wr_etype  = reg_wr & hit_etype;
    wire logic        wr_pcfg   = reg_wr & pcfg_hit;
    // saturates so a long overload never wraps to a small count
    wire logic        drop_inc  = drop & (drops_reg != DROPS_MAX); // RQ17

    logic [7:0]       busy_all;
    always_comb begin
        for (int i = 0; i < NQT; i++) begin
            busy_all[i] = (cnt_reg[i] != 3'h0);
        end
    end

    wire logic [31:0] rv_map    = {16'h0000, map_reg};
    wire logic [31:0] rv_etype  = {31'h0000_0000, etype_reg == ETYPE_ALT};
    wire logic [31:0] rv_stat   = {24'h00_0000, busy_all}; // RQ4
    wire logic [31:0] rv_drops  = {16'h0000, drops_reg};
    wire logic [31:0] rv_pcfg   = {13'h0000, pcfg_reg[pcfg_idx]};

    // unmapped offsets read as zero and ignore writes
    wire logic [31:0] rd_val    =
        hit_map   ? rv_map :
        hit_etype ? rv_etype :
        hit_stat  ? rv_stat :
        hit_drops ? rv_drops :
        pcfg_hit  ? rv_pcfg :
        32'h0000_0000;

    assign reg_rdata = rdata_reg;
    assign eg_etype  = etype_reg;

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_reg <= rd_val;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            map_reg <= MAP_RST; // RQ6
        end else if (wr_map) begin
            map_reg <= reg_wdata[15:0]; // RQ6
        end
    end

    // only two ethertypes exist, so one bit selects between them
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            etype_reg <= ETYPE_STD;
        end else if (wr_etype) begin
            etype_reg <= reg_wdata[0] ? ETYPE_ALT : ETYPE_STD; // RQ15
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NP; i++) begin
                pcfg_reg[i] <= PCFG_RST; // RQ16
            end
        end else if (wr_pcfg) begin
            pcfg_reg[pcfg_idx] <= reg_wdata[18:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            drops_reg <= 16'h0000;
        end else if (drop_inc) begin
            drops_reg <= drops_reg + 16'h0001; // RQ17
        end
    end

endmodule
